//--- include/aopm_defines.vh
`ifndef AOPM_DEFINES_VH
`define AOPM_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets and address groups
// ----------------------------------------------------------------------
`define AOPM_A_FREQ       8'h00
`define AOPM_A_DOFN       8'h04
`define AOPM_A_STAT       8'h08
`define AOPM_A_CLR        8'h0C
`define AOPM_A_IEN        8'h10
`define AOPM_A_PER        8'h14
`define AOPM_G_AOFN       4'h2
`define AOPM_G_SER        4'h3
`define AOPM_G_LIM        4'h4
`define AOPM_G_CRV        4'h5
`define AOPM_G_CMD        4'h6

// ----------------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------------
`define AOPM_PWM_USE_CODE 16'h0064
`define AOPM_UNUSED_CODE  16'h0000
`define AOPM_PLC_CODE     16'h0065
`define AOPM_SERIAL_CODE  16'h0066
`define AOPM_ECHO_CODE    16'h0BB9

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define AOPM_ST_PLCW      0
`define AOPM_ST_SHTX      1
`define AOPM_ST_FRNG      2
`define AOPM_CRV_EN       31
`define AOPM_FREQ_RST     12'h1F4
`define AOPM_LIM_RST      32'h03FF0000
`define AOPM_CRV_RST      32'h00000080
`define AOPM_PER_RST      27'h30D40

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AOPM_FREQ_MIN_HZ  12'h001
`define AOPM_FREQ_MAX_HZ  12'h9C4
`define AOPM_CLK_PERIOD_NS 10
`define AOPM_CLK_HZ       (1000000000 / `AOPM_CLK_PERIOD_NS)

`endif

//--- logic/aopm_top.v
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "aopm_defines.vh"

module aopm_top #(
    parameter NAO   = 4,
    parameter CW    = 10,
    parameter NSH   = 32
) (
    input  wire              core_clk_i,
    input  wire              rst_n_i,
    input  wire [7:0]        reg_addr_i,
    input  wire [31:0]       reg_wdata_i,
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    output reg  [31:0]       reg_rdata_o,
    input  wire [NAO*CW-1:0] seq_cmd_i,
    input  wire [NAO*CW-1:0] meas_i,
    input  wire              plc_ao_wr_i,
    input  wire [1:0]        plc_ao_idx_i,
    input  wire [CW-1:0]     plc_ao_val_i,
    input  wire              plc_sh_wr_i,
    input  wire [4:0]        plc_sh_idx_i,
    input  wire [15:0]       plc_sh_val_i,
    input  wire [1:0]        do_level_i,
    output reg  [NAO*CW-1:0] ao_cmd_o,
    output reg  [NAO-1:0]    ao_active_o,
    output reg               pwm_analog_out_a_o,
    output reg               pwm_analog_out_b_o,
    output reg               can_sh_valid_o,
    output reg  [4:0]        can_sh_idx_o,
    output reg  [15:0]       can_sh_data_o,
    output reg               irq_o
);

    // ------------------------------------------------------------------
    // Constants and state
    // ------------------------------------------------------------------
    localparam [31:0] CLK_HZ = `AOPM_CLK_HZ;
    localparam        D_IDLE = 1'b0;
    localparam        D_RUN  = 1'b1;

    reg  [11:0]   freq_q;
    reg  [31:0]   dofn_q;
    reg  [2:0]    stat_q;
    reg  [2:0]    ien_q;
    reg  [15:0]   aofn_q [0:NAO-1];
    reg  [CW-1:0] ser_q  [0:NAO-1];
    reg  [CW-1:0] plc_q  [0:NAO-1];
    reg  [31:0]   lim_q  [0:NAO-1];
    reg  [31:0]   crv_q  [0:NAO-1];
    reg  [15:0]   sh_q   [0:NSH-1];
    reg  [CW-1:0] cmd_q  [0:NAO-1];
    wire [CW-1:0] cmd_d  [0:NAO-1];

    reg           dst_q;
    reg  [4:0]    dcnt_q;
    reg  [26:0]   drem_q;
    reg  [26:0]   dquo_q;
    reg  [26:0]   per_new_q;
    reg  [26:0]   per_q;
    reg  [26:0]   cnt_q;
    reg  [26:0]   hi_a_q;
    reg  [26:0]   hi_b_q;

    wire [3:0]    grp = reg_addr_i[7:4];
    wire [1:0]    rix = reg_addr_i[3:2];
    wire          wr_freq = reg_wr_i && (reg_addr_i == `AOPM_A_FREQ);
    wire [11:0]   freq_w = reg_wdata_i[11:0];
    wire          freq_bad = (freq_w < `AOPM_FREQ_MIN_HZ) || (freq_w > `AOPM_FREQ_MAX_HZ);
    wire          plc_bad = plc_ao_wr_i && (aofn_q[plc_ao_idx_i] != `AOPM_PLC_CODE);
    wire          wrap = (cnt_q >= per_q - 27'h1) || (cnt_q >= per_new_q - 27'h1);
    wire [36:0]   hi_a_w = per_new_q * cmd_q[2];
    wire [36:0]   hi_b_w = per_new_q * cmd_q[3];
    wire [2:0]    ev = {wr_freq && freq_bad, plc_sh_wr_i, plc_bad};
    wire [27:0]   dtry = {drem_q, CLK_HZ[dcnt_q]} - {16'h0000, freq_q};

    integer i;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------

    // Software-written configuration; out-of-range frequencies are clamped.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freq_q <= `AOPM_FREQ_RST;
            dofn_q <= 32'h00000000;
            ien_q  <= 3'h0;
            for (i = 0; i < NAO; i = i + 1) begin
                aofn_q[i] <= `AOPM_UNUSED_CODE;
                ser_q[i]  <= {CW{1'b0}};
                lim_q[i]  <= `AOPM_LIM_RST;
                crv_q[i]  <= `AOPM_CRV_RST;
            end
        end else if (reg_wr_i) begin
            if (reg_addr_i == `AOPM_A_FREQ) begin
                if (freq_w < `AOPM_FREQ_MIN_HZ) begin
                    freq_q <= `AOPM_FREQ_MIN_HZ;
                end else if (freq_w > `AOPM_FREQ_MAX_HZ) begin
                    freq_q <= `AOPM_FREQ_MAX_HZ;
                end else begin
                    freq_q <= freq_w;
                end
            end
            if (reg_addr_i == `AOPM_A_DOFN) begin
                dofn_q <= reg_wdata_i;
            end
            if (reg_addr_i == `AOPM_A_IEN) begin
                ien_q <= reg_wdata_i[2:0];
            end
            if (grp == `AOPM_G_AOFN) begin
                aofn_q[rix] <= reg_wdata_i[15:0];
            end
            if (grp == `AOPM_G_SER) begin
                ser_q[rix] <= reg_wdata_i[CW-1:0];
            end
            if (grp == `AOPM_G_LIM) begin
                lim_q[rix] <= reg_wdata_i;
            end
            if (grp == `AOPM_G_CRV) begin
                crv_q[rix] <= reg_wdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // PLC values and shared broadcast
    // ------------------------------------------------------------------

    // PLC output values are kept only for outputs the PLC owns.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (i = 0; i < NAO; i = i + 1) begin
                plc_q[i] <= {CW{1'b0}};
            end
        end else if (plc_ao_wr_i && !plc_bad) begin
            plc_q[plc_ao_idx_i] <= plc_ao_val_i;
        end
    end

    // Each shared write is stored and sent once toward the peer bus.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (i = 0; i < NSH; i = i + 1) begin
                sh_q[i] <= 16'h0000;
            end
            can_sh_valid_o <= 1'b0;
            can_sh_idx_o   <= 5'h00;
            can_sh_data_o  <= 16'h0000;
        end else begin
            can_sh_valid_o <= plc_sh_wr_i;
            if (plc_sh_wr_i) begin
                sh_q[plc_sh_idx_i] <= plc_sh_val_i;
                can_sh_idx_o       <= plc_sh_idx_i;
                can_sh_data_o      <= plc_sh_val_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------

    // Sticky events; a new event wins over a clear in the same cycle.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= 3'h0;
            irq_o  <= 1'b0;
        end else begin
            if (reg_wr_i && (reg_addr_i == `AOPM_A_CLR)) begin
                stat_q <= (stat_q & ~reg_wdata_i[2:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            irq_o <= |(stat_q & ien_q);
        end
    end

    // ------------------------------------------------------------------
    // Command path per analogue output
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NAO; g = g + 1) begin : g_ao
            wire [15:0]   fn     = aofn_q[g];
            wire          f_plc  = (fn == `AOPM_PLC_CODE);
            wire          f_ser  = (fn == `AOPM_SERIAL_CODE);
            wire          f_echo = (fn >= `AOPM_ECHO_CODE);
            wire          f_off  = (fn == `AOPM_UNUSED_CODE);
            wire [15:0]   m_off  = fn - `AOPM_ECHO_CODE;
            wire [1:0]    m_ix   = m_off[1:0];
            wire [CW-1:0] meas   = meas_i[m_ix*CW +: CW];
            wire [CW-1:0] seq    = seq_cmd_i[g*CW +: CW];
            wire [CW-1:0] raw    = f_echo ? meas : seq;
            wire [17:0]   prod   = raw * crv_q[g][7:0];
            wire [10:0]   cv     = {1'b0, prod[16:7]} + {1'b0, crv_q[g][25:16]};
            wire [CW-1:0] cvc    = (cv[10] || prod[17]) ? {CW{1'b1}} : cv[CW-1:0];
            wire          use_cv = f_echo || crv_q[g][`AOPM_CRV_EN];
            wire [CW-1:0] src    = f_plc ? plc_q[g] : (f_ser ? ser_q[g] :
                                   (use_cv ? cvc : raw));
            wire [CW-1:0] lmin   = lim_q[g][CW-1:0];
            wire [CW-1:0] lmax   = lim_q[g][16+CW-1:16];
            wire [CW-1:0] span   = (lmax > lmin) ? (lmax - lmin) : {CW{1'b0}};
            wire [2*CW-1:0] sp   = span * src;
            wire [CW-1:0] lim    = lmin + sp[2*CW-1:CW];
            assign cmd_d[g] = f_off ? {CW{1'b0}} : lim;

            // Command and activity are registered before leaving the block.
            always @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cmd_q[g]                 <= {CW{1'b0}};
                    ao_cmd_o[g*CW +: CW]     <= {CW{1'b0}};
                    ao_active_o[g]           <= 1'b0;
                end else begin
                    cmd_q[g]                 <= cmd_d[g];
                    ao_cmd_o[g*CW +: CW]     <= cmd_d[g];
                    ao_active_o[g]           <= !f_off;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Period divider
    // ------------------------------------------------------------------

    // Restoring divide of the clock rate by the frequency, one bit a cycle.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dst_q     <= D_IDLE;
            dcnt_q    <= 5'h00;
            drem_q    <= 27'h0000000;
            dquo_q    <= 27'h0000000;
            per_new_q <= `AOPM_PER_RST;
        end else begin
            case (dst_q)
                D_IDLE: begin
                    if (wr_freq) begin
                        dst_q  <= D_RUN;
                        dcnt_q <= 5'h1A;
                        drem_q <= 27'h0000000;
                        dquo_q <= 27'h0000000;
                    end
                end
                D_RUN: begin
                    if (!dtry[27]) begin
                        drem_q <= dtry[26:0];
                        dquo_q <= {dquo_q[25:0], 1'b1};
                    end else begin
                        drem_q <= {drem_q[25:0], CLK_HZ[dcnt_q]};
                        dquo_q <= {dquo_q[25:0], 1'b0};
                    end
                    if (wr_freq) begin
                        dcnt_q <= 5'h1A;
                        drem_q <= 27'h0000000;
                        dquo_q <= 27'h0000000;
                    end else if (dcnt_q == 5'h00) begin
                        dst_q     <= D_IDLE;
                        per_new_q <= dtry[27] ? {dquo_q[25:0], 1'b0}
                                              : {dquo_q[25:0], 1'b1};
                    end else begin
                        dcnt_q <= dcnt_q - 5'h01;
                    end
                end
                default: begin
                    dst_q <= D_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // PWM generation
    // ------------------------------------------------------------------

    // Shared period counter; a shorter new period ends the running one early.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            per_q  <= `AOPM_PER_RST;
            cnt_q  <= 27'h0000000;
            hi_a_q <= 27'h0000000;
            hi_b_q <= 27'h0000000;
        end else if (wrap) begin
            cnt_q  <= 27'h0000000;
            per_q  <= per_new_q;
            hi_a_q <= hi_a_w[36:10];
            hi_b_q <= hi_b_w[36:10];
        end else begin
            cnt_q <= cnt_q + 27'h0000001;
        end
    end

    // Pins carry PWM only in PWM-use mode, else the plain digital level.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_analog_out_a_o <= 1'b0;
            pwm_analog_out_b_o <= 1'b0;
        end else begin
            pwm_analog_out_a_o <= (dofn_q[15:0] == `AOPM_PWM_USE_CODE) ?
                                  (cnt_q < hi_a_q) : do_level_i[0];
            pwm_analog_out_b_o <= (dofn_q[31:16] == `AOPM_PWM_USE_CODE) ?
                                  (cnt_q < hi_b_q) : do_level_i[1];
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------

    // Read data stands in the cycle after the strobe; unmapped reads zero.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            if (reg_addr_i[7]) begin
                reg_rdata_o <= {16'h0000, sh_q[reg_addr_i[6:2]]};
            end else if (reg_addr_i == `AOPM_A_FREQ) begin
                reg_rdata_o <= {20'h00000, freq_q};
            end else if (reg_addr_i == `AOPM_A_DOFN) begin
                reg_rdata_o <= dofn_q;
            end else if (reg_addr_i == `AOPM_A_STAT) begin
                reg_rdata_o <= {29'h00000000, stat_q};
            end else if (reg_addr_i == `AOPM_A_IEN) begin
                reg_rdata_o <= {29'h00000000, ien_q};
            end else if (reg_addr_i == `AOPM_A_PER) begin
                reg_rdata_o <= {5'h00, per_q};
            end else if (grp == `AOPM_G_AOFN) begin
                reg_rdata_o <= {16'h0000, aofn_q[rix]};
            end else if (grp == `AOPM_G_SER) begin
                reg_rdata_o <= {22'h000000, ser_q[rix]};
            end else if (grp == `AOPM_G_LIM) begin
                reg_rdata_o <= lim_q[rix];
            end else if (grp == `AOPM_G_CRV) begin
                reg_rdata_o <= crv_q[rix];
            end else if (grp == `AOPM_G_CMD) begin
                reg_rdata_o <= {22'h000000, cmd_q[rix]};
            end else begin
                reg_rdata_o <= 32'h00000000;
            end
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule

//--- dv/aopm_chk.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Port checker for the analogue output mapper
// ----------------------------------------------------------------------
module aopm_chk #(
    parameter NAO = 4,
    parameter CW  = 10
) (
    input wire              core_clk_i,
    input wire              rst_n_i,
    input wire [7:0]        reg_addr_i,
    input wire              reg_rd_i,
    input wire [31:0]       reg_rdata_o,
    input wire              plc_sh_wr_i,
    input wire [4:0]        plc_sh_idx_i,
    input wire [15:0]       plc_sh_val_i,
    input wire [NAO*CW-1:0] ao_cmd_o,
    input wire [NAO-1:0]    ao_active_o,
    input wire              can_sh_valid_o,
    input wire [4:0]        can_sh_idx_o,
    input wire [15:0]       can_sh_data_o,
    input wire              irq_o,
    input wire              pwm_analog_out_a_o
);
    // All properties share the core clock and are quiet in reset.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // A shared write is broadcast in the next cycle with its index and value.
    property p_sh_pulse;
        plc_sh_wr_i |=> can_sh_valid_o && can_sh_idx_o == $past(plc_sh_idx_i)
            && can_sh_data_o == $past(plc_sh_val_i);
    endproperty
    a_sh_pulse: assert property (p_sh_pulse) else $error("shared value not sent");

    property p_sh_only;
        !plc_sh_wr_i |=> !can_sh_valid_o;
    endproperty
    a_sh_only: assert property (p_sh_only) else $error("spurious broadcast");

    property p_sh_hold;
        !can_sh_valid_o |-> $stable(can_sh_idx_o) && $stable(can_sh_data_o);
    endproperty
    a_sh_hold: assert property (p_sh_hold) else $error("broadcast data moved");

    // Output 0, when it stays unused, carries no command.
    property p_unused;
        (!ao_active_o[0]) [*3] |-> ao_cmd_o[CW-1:0] == '0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused output commanded");

    // The frequency and period read back inside their legal ranges.
    property p_freq_rng;
        reg_rd_i && reg_addr_i == 8'h00 |=>
            reg_rdata_o >= 32'h00000001 && reg_rdata_o <= 32'h000009C4;
    endproperty
    a_freq_rng: assert property (p_freq_rng) else $error("frequency out of range");

    property p_per_rng;
        reg_rd_i && reg_addr_i == 8'h14 |=>
            reg_rdata_o >= 32'h00009C40 && reg_rdata_o <= 32'h05F5E100;
    endproperty
    a_per_rng: assert property (p_per_rng) else $error("period out of range");

    // The command register shows the command present at the read.
    property p_cmd_rb;
        reg_rd_i && reg_addr_i == 8'h60 |=>
            reg_rdata_o == {{(32-CW){1'b0}}, $past(ao_cmd_o[CW-1:0])};
    endproperty
    a_cmd_rb: assert property (p_cmd_rb) else $error("command readback wrong");

    property p_clr_wo;
        reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o == 32'h00000000;
    endproperty
    a_clr_wo: assert property (p_clr_wo) else $error("clear register readable");

    // Main scenarios reached.
    c_sh: cover property (can_sh_valid_o);
    c_irq: cover property ($rose(irq_o));
    c_pwm: cover property ($rose(pwm_analog_out_a_o));
endmodule

bind aopm_top aopm_chk #(.NAO(NAO), .CW(CW)) u_aopm_chk (
    .core_clk_i, .rst_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
    .plc_sh_wr_i, .plc_sh_idx_i, .plc_sh_val_i, .ao_cmd_o, .ao_active_o,
    .can_sh_valid_o, .can_sh_idx_o, .can_sh_data_o, .irq_o, .pwm_analog_out_a_o
);

//--- dv/aopm_pwm_rx.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Regulator input model: measures period and high time of a PWM pin
// ----------------------------------------------------------------------
module aopm_pwm_rx (
    input  wire        core_clk_i,
    input  wire        rst_n_i,
    input  wire        pin_i,
    output reg  [31:0] hi_q,
    output reg  [31:0] per_q
);
    reg        last_q;
    reg [31:0] cnt_q;
    reg [31:0] hcnt_q;

    // Each rising edge closes one period and publishes its figures.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {last_q, cnt_q, hcnt_q, hi_q, per_q} <= '0;
        end else begin
            last_q <= pin_i;
            if (pin_i && !last_q) begin
                per_q  <= cnt_q;
                hi_q   <= hcnt_q;
                cnt_q  <= 32'h00000001;
                hcnt_q <= 32'h00000001;
            end else begin
                cnt_q  <= cnt_q + 32'h00000001;
                hcnt_q <= hcnt_q + {31'h0, pin_i};
            end
        end
    end
endmodule

//--- dv/aopm_top_tb.sv
`timescale 1ns/1ns
module aopm_top_tb;
    logic         core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, plc_ao_wr_i, plc_sh_wr_i;
    logic [7:0]   reg_addr_i;
    logic [31:0]  reg_wdata_i;
    logic [39:0]  seq_cmd_i, meas_i;
    logic [1:0]   plc_ao_idx_i, do_level_i;
    logic [9:0]   plc_ao_val_i;
    logic [4:0]   plc_sh_idx_i;
    logic [15:0]  plc_sh_val_i;
    wire  [31:0]  reg_rdata_o, hi_a, per_a, hi_b, per_b;
    wire  [39:0]  ao_cmd_o;
    wire  [3:0]   ao_active_o;
    wire          pwm_analog_out_a_o, pwm_analog_out_b_o, can_sh_valid_o, irq_o;
    wire  [4:0]   can_sh_idx_o;
    wire  [15:0]  can_sh_data_o;
    int           bad_count, cmp_count, k;
    logic [31:0]  d;
    logic [109:0] rows [8];

    aopm_top DUT (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .seq_cmd_i, .meas_i, .plc_ao_wr_i, .plc_ao_idx_i, .plc_ao_val_i,
        .plc_sh_wr_i, .plc_sh_idx_i, .plc_sh_val_i, .do_level_i, .ao_cmd_o, .ao_active_o,
        .pwm_analog_out_a_o, .pwm_analog_out_b_o, .can_sh_valid_o, .can_sh_idx_o,
        .can_sh_data_o, .irq_o);
    aopm_pwm_rx rx_a (.core_clk_i, .rst_n_i, .pin_i(pwm_analog_out_a_o), .hi_q(hi_a),
        .per_q(per_a));
    aopm_pwm_rx rx_b (.core_clk_i, .rst_n_i, .pin_i(pwm_analog_out_b_o), .hi_q(hi_b),
        .per_q(per_b));

    // ------------------------------------------------------------------
    // Bus, compare and closing helpers
    // ------------------------------------------------------------------
    function automatic int hi_of(int v);
        return (40000 * ((1023 * v) >> 10)) >> 10;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= w;
        reg_wr_i    <= 1'h1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'h1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'h0;
        #1;
        d = reg_rdata_o;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, e, d);
    endtask
    task automatic plc(input logic [1:0] i, input logic [9:0] v);
        @(posedge core_clk_i);
        plc_ao_wr_i  <= 1'h1;
        plc_ao_idx_i <= i;
        plc_ao_val_i <= v;
        @(posedge core_clk_i);
        plc_ao_wr_i <= 1'h0;
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Free-running core clock.
    initial begin
        core_clk_i = 1'h0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Watchdog covers the long wait for the first period wrap.
    initial begin
        repeat (95000) @(posedge core_clk_i);
        bad_count++;
        $display("watchdog expired");
        test_done;
    end

    // Rows: function, source, serial value, limits, curve, expected command.
    initial begin
        rows[0] = {16'h0000, 10'h200, 10'h000, 32'h03FF0000, 32'h00000080, 10'h000};
        rows[1] = {16'h0001, 10'h200, 10'h000, 32'h03FF0000, 32'h00000080, 10'h1FF};
        rows[2] = {16'h0066, 10'h200, 10'h100, 32'h03FF0000, 32'h800000FF, 10'h0FF};
        rows[3] = {16'h0BB9, 10'h200, 10'h000, 32'h03FF0000, 32'h00100040, 10'h10F};
        rows[4] = {16'h0001, 10'h200, 10'h000, 32'h03FF0000, 32'h800000C0, 10'h2FF};
        rows[5] = {16'h0001, 10'h200, 10'h000, 32'h03000100, 32'h00000080, 10'h200};
        rows[6] = {16'h0001, 10'h3FF, 10'h000, 32'h01000200, 32'h00000080, 10'h200};
        rows[7] = {16'h0001, 10'h3FF, 10'h000, 32'h03FF0000, 32'h800000FF, 10'h3FE};
        {rst_n_i, reg_wr_i, reg_rd_i, plc_ao_wr_i, plc_sh_wr_i} = '0;
        {reg_addr_i, reg_wdata_i, seq_cmd_i, meas_i, plc_ao_idx_i, do_level_i} = '0;
        {plc_ao_val_i, plc_sh_idx_i, plc_sh_val_i} = '0;
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'h1;
        rchk("freq", 8'h00, 32'h000001F4);
        rchk("period", 8'h14, 32'h00030D40);
        rchk("limit", 8'h40, 32'h03FF0000);
        rchk("curve", 8'h50, 32'h00000080);
        rchk("clear", 8'h0C, 32'h00000000);
        rchk("unmapped", 8'h7C, 32'h00000000);
        chk("active", 32'h0, {28'h0, ao_active_o});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h20, {16'h0, rows[i][109:94]});
            wr(8'h30, {22'h0, rows[i][83:74]});
            wr(8'h40, rows[i][73:42]);
            wr(8'h50, rows[i][41:10]);
            seq_cmd_i[9:0] <= rows[i][93:84];
            meas_i[9:0]    <= rows[i][93:84];
            repeat (4) @(posedge core_clk_i);
            #1;
            chk("cmd", {22'h0, rows[i][9:0]}, {22'h0, ao_cmd_o[9:0]});
            chk("act", {31'h0, rows[i][109:94] != 16'h0}, {31'h0, ao_active_o[0]});
            rchk("cmd reg", 8'h60, {22'h0, rows[i][9:0]});
        end
        $display("test rows done");
        // A write to a sequence output is dropped and warns.
        wr(8'h24, 32'h00000001);
        wr(8'h10, 32'h00000001);
        seq_cmd_i[19:10] <= 10'h100;
        plc(2'h1, 10'h2AB);
        repeat (4) @(posedge core_clk_i);
        #1;
        chk("dropped", 32'h0FF, {22'h0, ao_cmd_o[19:10]});
        chk("irq on", 32'h1, {31'h0, irq_o});
        wr(8'h10, 32'h00000000);
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("irq masked", 32'h0, {31'h0, irq_o});
        rchk("warn", 8'h08, 32'h00000001);
        wr(8'h10, 32'h00000001);
        wr(8'h0C, 32'h00000001);
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("irq off", 32'h0, {31'h0, irq_o});
        // Once owned, only the PLC value drives the output.
        wr(8'h24, 32'h00000065);
        plc(2'h1, 10'h2AB);
        seq_cmd_i[19:10] <= 10'h3FF;
        repeat (4) @(posedge core_clk_i);
        #1;
        chk("owned", 32'h2AA, {22'h0, ao_cmd_o[19:10]});
        rchk("no warn", 8'h08, 32'h00000000);
        $display("test plc done");
        // Two shared writes back to back.
        @(posedge core_clk_i);
        plc_sh_wr_i  <= 1'h1;
        plc_sh_idx_i <= 5'h1F;
        plc_sh_val_i <= 16'hBEEF;
        @(posedge core_clk_i);
        plc_sh_idx_i <= 5'h00;
        plc_sh_val_i <= 16'h1234;
        @(posedge core_clk_i);
        plc_sh_wr_i <= 1'h0;
        #1;
        chk("sh data", 32'h1234, {16'h0, can_sh_data_o});
        rchk("sh 31", 8'hFC, 32'h0000BEEF);
        rchk("sh 0", 8'h80, 32'h00001234);
        rchk("sh stat", 8'h08, 32'h00000002);
        wr(8'h0C, 32'h00000002);
        $display("test shared done");
        // Frequency bounds are clamped and flagged.
        wr(8'h00, 32'h00000000);
        rchk("freq lo", 8'h00, 32'h00000001);
        rchk("clamp", 8'h08, 32'h00000004);
        wr(8'h00, 32'h00000FFF);
        rchk("freq hi", 8'h00, 32'h000009C4);
        wr(8'h0C, 32'h00000004);
        wr(8'h00, 32'h000009C4);
        // Plain digital outputs follow their levels.
        do_level_i <= 2'h1;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk("do", 32'h1, {30'h0, pwm_analog_out_b_o, pwm_analog_out_a_o});
        do_level_i <= 2'h2;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk("do", 32'h2, {30'h0, pwm_analog_out_b_o, pwm_analog_out_a_o});
        $display("test digital done");
        // Both pins as PWM with different duties at 2500 Hz.
        wr(8'h04, 32'h00640064);
        wr(8'h28, 32'h00000001);
        wr(8'h2C, 32'h00000001);
        seq_cmd_i[39:20] <= {10'h300, 10'h100};
        do_level_i <= 2'h3;
        d = 32'h0;
        for (k = 0; k < 60 && d !== 32'h00009C40; k++) begin
            repeat (1000) @(posedge core_clk_i);
            rd(8'h14);
        end
        chk("period", 32'h00009C40, d);
        repeat (41000) @(posedge core_clk_i);
        #1;
        chk("per a", 32'h00009C40, per_a);
        chk("per b", 32'h00009C40, per_b);
        chk("duty a", hi_of(256), hi_a);
        chk("duty b", hi_of(768), hi_b);
        $display("test pwm done");
        test_done;
    end
endmodule
